// *** design/atcp_ctrl_port.sv ***
`include "atcp_defs.svh"

// Serial control port and transmitter control registers
module atcp_ctrl_port (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Mode strap: high selects software mode
  input wire logic i_sw_mode,
  // Serial control pins
  input wire logic i_cs_n,
  input wire logic i_ctrl_serial_clock,
  input wire logic i_ctrl_serial_in,
  output logic o_ctrl_serial_out,
  output logic o_ctrl_serial_out_oe,
  // Encoded sources for the line driver
  input wire logic i_encoder_bit,
  input wire logic i_external_encoded_in,
  // Line driver outputs
  output logic o_line_pos,
  output logic o_line_neg,
  // Audio serial port settings for the encoder path
  output logic [7:0] o_asp_ctrl,
  // Block start pin direction and routing
  output logic o_block_start_pin_oe,
  output atcp_pkg::atcp_route_t o_route,
  // Core reset and power state
  output logic o_core_reset,
  output logic o_powered_down
);
  // Complete module state
  typedef struct packed {
    atcp_pkg::atcp_phase_t phase;
    logic clk_prev;
    logic [4:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] out_byte;
    logic rd;
    logic step;
    logic [5:0] addr;
    logic [7:0] txctl;
    logic [7:0] pwrclk;
    logic [7:0] aspctl;
    logic sdo;
    logic sdo_oe;
    logic line_pos;
    logic line_neg;
    logic bls_oe;
    atcp_pkg::atcp_route_t route;
    logic core_reset;
    logic power_down_bit;
  } atcp_state_t;

  atcp_state_t q;
  atcp_state_t d;
  atcp_pkg::atcp_pins_t pins;
  atcp_pkg::atcp_txctl_t tx;
  logic rise;
  logic fall;
  logic [7:0] shifted;
  logic [5:0] next_addr;
  logic src_bit;
  logic line_off;
  logic [1:0] strap_pins;
  logic sw_mode;
  logic ext_in;

  // Pins cross into the system clock before any use
  atcp_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({i_cs_n, i_ctrl_serial_clock, i_ctrl_serial_in}),
    .o_sync(pins)
  );

  // Mode strap and external encoded stream are pins too
  atcp_sync #(
    .WIDTH(2)
  ) u_strap_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({i_sw_mode, i_external_encoded_in}),
    .o_sync(strap_pins)
  );
  assign sw_mode = strap_pins[1];
  assign ext_in = strap_pins[0];

  // Register read decode, used for first and later read bytes
  function automatic logic [7:0] reg_read(
    input logic [5:0] a,
    input logic [7:0] txc,
    input logic [7:0] pc,
    input logic [7:0] asp
  );
    logic [7:0] v;
    v = 8'h00;
    case (a)
      `ATCP_REG_TXCTL: v = txc;
      `ATCP_REG_PWRCLK: v = pc & `ATCP_PWRCLK_MASK;
      `ATCP_REG_ASPCTL: v = asp;
      default: v = 8'h00; // Factory and unmapped read zero
    endcase
    return v;
  endfunction : reg_read

  // Edge detection on the synchronised serial clock
  assign rise = pins.clk & ~q.clk_prev; // R07
  assign fall = ~pins.clk & q.clk_prev; // R07
  assign shifted = {q.shreg[6:0], pins.din}; // R08
  assign next_addr = q.addr + (q.step ? 6'h02 : 6'h01); // R11
  assign tx = atcp_pkg::atcp_txctl_t'(q.txctl);

  // Line driver source selection
  always_comb begin
    // Hardware mode ignores the bypass setting
    src_bit = (sw_mode && tx.bypass) ? ext_in : i_encoder_bit; // R01 R02
    line_off = q.core_reset || q.power_down_bit || (sw_mode && tx.line_output_disable);
  end

  // Next-state logic for the port and registers
  always_comb begin
    d = q;
    d.clk_prev = pins.clk;
    // Deselect aborts any partial transfer
    if (pins.cs_n) begin
      d.phase = atcp_pkg::ATCP_IDLE; // R05
      d.bit_cnt = 5'h00;
      d.sdo_oe = 1'b0; // R06
    end else begin
      if (q.phase == atcp_pkg::ATCP_IDLE) begin
        d.phase = atcp_pkg::ATCP_HDR;
      end
      if (rise) begin
        d.shreg = shifted;
        d.bit_cnt = q.bit_cnt + 5'h01;
        if (q.phase != atcp_pkg::ATCP_DATA) begin
          // First header byte carries direction, step, address
          if (q.bit_cnt == 5'h07) begin
            d.rd = shifted[7]; // R09
            d.step = shifted[6];
            d.addr = shifted[5:0];
          end
          // Second header byte is discarded
          if (q.bit_cnt == 5'(`ATCP_HDR_BITS - 1)) begin // R10
            d.phase = atcp_pkg::ATCP_DATA;
            d.bit_cnt = 5'h00;
            d.out_byte = reg_read(q.addr, q.txctl, q.pwrclk, q.aspctl); // R13
          end
        end else if (q.bit_cnt == 5'(`ATCP_BYTE_BITS - 1)) begin
          d.bit_cnt = 5'h00;
          if (!q.rd) begin
            // Write lands on current address then steps
            case (q.addr)
              `ATCP_REG_TXCTL: d.txctl = shifted; // R12
              `ATCP_REG_PWRCLK: d.pwrclk = shifted & `ATCP_PWRCLK_MASK;
              `ATCP_REG_ASPCTL: d.aspctl = shifted;
              default: d.txctl = q.txctl;
            endcase
            d.addr = next_addr; // R11
          end else begin
            d.addr = next_addr; // R11
            d.out_byte = reg_read(next_addr, q.txctl, q.pwrclk, q.aspctl);
          end
        end
      end
      // Output changes on falling edge, MSB first
      if (fall && q.phase == atcp_pkg::ATCP_DATA && q.rd) begin
        d.sdo_oe = 1'b1; // R06
        d.sdo = q.out_byte[3'(7 - q.bit_cnt[2:0])]; // R07 R08 R13
      end
    end
    // Software reset restores transmitter and audio port registers but leaves power control
    if (q.pwrclk[`ATCP_PC_SWRST]) begin
      d.txctl = `ATCP_TXCTL_RST; // R14
      d.aspctl = `ATCP_ASPCTL_RST;
    end
    d.core_reset = q.pwrclk[`ATCP_PC_SWRST]; // R14
    d.power_down_bit = q.pwrclk[`ATCP_PC_PDN]; // R21
    // Grounded outputs during reset, power-down, software-mode disable
    d.line_pos = line_off ? 1'b0 : src_bit; // R03 R04 R21
    d.line_neg = line_off ? 1'b0 : ~src_bit; // R03 R04
    d.bls_oe = sw_mode && tx.block_start_pin_dir; // R15
    d.route.mute_audio = tx.mute; // R17
    d.route.mono_audio = tx.mono; // R18
    d.route.audio_from_right = tx.mono && tx.channel_pick; // R19
    d.route.shared_status = tx.shared_status_select; // R20
    d.route.status_from_right = tx.shared_status_select
      && tx.channel_pick; // R19 R20
    d.route.validity = tx.validity_flag; // R16
    d.route.clk_ratio = q.pwrclk[`ATCP_PC_CLK_LO +: 2]; // R22
  end

  // Single state register; reset values for all fields
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      q <= '0;
      q.phase <= atcp_pkg::ATCP_IDLE;
      q.clk_prev <= 1'b1;
      q.txctl <= `ATCP_TXCTL_RST; // R04 R15 R16 R17 R18
      q.pwrclk <= `ATCP_PWRCLK_RST; // R14 R21 R22
      q.aspctl <= `ATCP_ASPCTL_RST;
      q.core_reset <= 1'b1; // R03
      q.power_down_bit <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign o_ctrl_serial_out = q.sdo;
  assign o_ctrl_serial_out_oe = q.sdo_oe;
  assign o_line_pos = q.line_pos;
  assign o_line_neg = q.line_neg;
  assign o_asp_ctrl = q.aspctl;
  assign o_block_start_pin_oe = q.bls_oe;
  assign o_route = q.route;
  assign o_core_reset = q.core_reset;
  assign o_powered_down = q.power_down_bit;
endmodule : atcp_ctrl_port

// *** pkg/atcp_defs.svh ***
`ifndef ATCP_DEFS_SVH
`define ATCP_DEFS_SVH
// Notes on behaviour
// R01: Software mode: bypass 0 feeds line driver from encoder, 1 from external input.
// R02: Hardware mode always feeds the line driver from the internal encoder.
// R03: Line outputs held low during any reset and while powered down.
// R04: Output-disable bit 1 grounds line outputs; resets to 0. Code honours it in software mode only.
// R05: Host holds chip select low for a whole transfer.
// R06: Serial output high impedance when chip select high or not reading.
// R07: Input sampled on serial clock rise, output changed on fall.
// R08: Every byte travels most significant bit first.
// R09: 16-bit header: direction bit, step bit, 6-bit address, then spare byte.
// R10: Second header byte is ignored entirely.
// R11: Auto-increment adds one when step is 0, two when step is 1.
// R12: Write data follows header; chip select kept low writes following addresses.
// R13: Read data shifts out right after header; continues while select low.
// R14: Power control bit 3 is software reset, holds device reset; resets 0.
// R15: Block-start direction bit: 0 pin input, 1 pin output; resets 0. Code drives the pin in software mode only.
// R16: Validity flag sent from register bit; 1 marks invalid data; resets 0.
// R17: Mute bit 1 sends all-zero audio in both subframes; resets 0.
// R18: Mono bit: 0 stereo, 1 mono; resets 0.
// R19: Channel pick selects status, audio or both source per mono/shared bits.
// R20: Shared status 0 sends own status per subframe; 1 sends picked channel.
// R21: Power-down bit resets to 1; when 1 device powered down, outputs grounded.
// R22: Clock-rate bits: 00=128, 01=256 reset, 10=384, 11=512 times sample rate.

// Register offsets
`define ATCP_REG_FACTORY 6'h00
`define ATCP_REG_TXCTL 6'h01
`define ATCP_REG_PWRCLK 6'h02
`define ATCP_REG_ASPCTL 6'h03

// Transmitter control fields
`define ATCP_TX_BLS_DIR 0
`define ATCP_TX_VALID 1
`define ATCP_TX_MUTE 2
`define ATCP_TX_BYPASS 3
`define ATCP_TX_MONO 4
`define ATCP_TX_PICK 5
`define ATCP_TX_SHARED 6
`define ATCP_TX_OFF 7

// Power and clock fields
`define ATCP_PC_PDN 0
`define ATCP_PC_CLK_LO 1
`define ATCP_PC_SWRST 3

// Reset values
`define ATCP_TXCTL_RST 8'h00
`define ATCP_PWRCLK_RST 8'h03
`define ATCP_ASPCTL_RST 8'h00
`define ATCP_PWRCLK_MASK 8'h0F

// Serial framing
`define ATCP_HDR_BITS 16
`define ATCP_BYTE_BITS 8
`endif

// *** pkg/atcp_pkg.sv ***
package atcp_pkg;
  // Port sequencing phase
  typedef enum logic [1:0] {
    ATCP_IDLE,
    ATCP_HDR,
    ATCP_DATA
  } atcp_phase_t;

  // Synchronised serial pins
  typedef struct packed {
    logic cs_n;
    logic clk;
    logic din;
  } atcp_pins_t;

  // Decoded transmitter settings
  typedef struct packed {
    logic line_output_disable;
    logic shared_status_select;
    logic channel_pick;
    logic mono;
    logic bypass;
    logic mute;
    logic validity_flag;
    logic block_start_pin_dir;
  } atcp_txctl_t;

  // Audio and status routing to the encoder
  typedef struct packed {
    logic mute_audio;
    logic mono_audio;
    logic audio_from_right;
    logic shared_status;
    logic status_from_right;
    logic validity;
    logic [1:0] clk_ratio;
  } atcp_route_t;
endpackage : atcp_pkg

// *** design/atcp_sync.sv ***
// Two-stage synchroniser for a group of pins
module atcp_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Asynchronous inputs and synchronised outputs
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } atcp_sync_state_t;

  atcp_sync_state_t state_q;
  atcp_sync_state_t state_d;

  // First stage feeds only the second stage
  always_comb begin
    state_d.meta = i_async;
    state_d.stable = state_q.meta;
  end

  // Idle pins reset high so chip select reads deselected
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= '1;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_sync = state_q.stable;
endmodule : atcp_sync

// *** dv/atcp_host.sv ***
// Host side of the serial control port, one bit every 8 system clocks
module atcp_host (
  // Pacing clock
  input logic i_sys_clk,
  // Serial pins
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_sdi,
  input logic i_sdo
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];

  // Idle pins: deselected, clock parked low
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_sdi = 1'b0;
  end

  // Header bytes, then n data bytes from tx_q or into rx_q
  task automatic xfer(input logic [7:0] h1, input logic [7:0] h2,
                      input int n);
    logic [7:0] b;
    logic [7:0] r;
    o_cs_n <= 1'b0;
    for (int k = 0; k < n + 2; k++) begin
      b = (k == 0) ? h1 : (k == 1) ? h2 :
          h1[7] ? 8'($urandom) : tx_q.pop_front();
      for (int j = 7; j >= 0; j--) begin
        o_sdi <= b[j];
        repeat (4) @(negedge i_sys_clk);
        o_sclk <= 1'b1;
        repeat (4) @(negedge i_sys_clk);
        // Read bit is settled by the end of the high phase
        r[j] = i_sdo;
        o_sclk <= 1'b0;
      end
      if (h1[7] && k > 1) rx_q.push_back(r);
    end
    // Data line inverted so it shows no stale bit
    o_sdi <= ~o_sdi;
    repeat (4) @(negedge i_sys_clk);
    o_cs_n <= 1'b1;
    repeat (6) @(negedge i_sys_clk);
  endtask : xfer
endmodule : atcp_host

// *** dv/atcp_ctrl_port_assertions.sv ***
// Port-level checks of the control port
module atcp_chk (
  // Clock, reset and inputs
  input logic i_sys_clk,
  input logic i_rst,
  input logic i_sw_mode,
  input logic i_cs_n,
  input logic i_ctrl_serial_clock,
  input logic i_encoder_bit,
  // Watched outputs
  input logic o_ctrl_serial_out,
  input logic o_ctrl_serial_out_oe,
  input logic o_line_pos,
  input logic o_line_neg,
  input logic o_block_start_pin_oe,
  input atcp_pkg::atcp_route_t o_route,
  input logic o_core_reset,
  input logic o_powered_down
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // Deselect long enough for the synchroniser to drain
  sequence s_idle;
    i_cs_n [*5];
  endsequence
  // Hardware mode running with a steady encoder level
  sequence s_hw_run;
    (!i_sw_mode && !o_powered_down && !o_core_reset
     && $stable(i_encoder_bit)) [*4];
  endsequence
  chk_line_pair: assert property (!(o_line_pos && o_line_neg))
    else $error("line pair both high");
  chk_pdn_ground: assert property (
    o_powered_down [*2] |-> !o_line_pos && !o_line_neg)
    else $error("line live while powered down");
  chk_swrst_ground: assert property (
    o_core_reset [*2] |-> !o_line_pos && !o_line_neg)
    else $error("line live during soft reset");
  chk_reset_vals: assert property ($fell(i_rst) |->
    o_powered_down && o_core_reset && o_route == '0 && !o_line_pos)
    else $error("wrong state after reset");
  chk_oe_idle: assert property (
    s_idle |-> !o_ctrl_serial_out_oe)
    else $error("data out driven while deselected");
  chk_out_steady: assert property (
    !i_cs_n && $rose(i_ctrl_serial_clock)
    |=> $stable(o_ctrl_serial_out) [*5])
    else $error("data out moved near rising clock");
  chk_bls_hw: assert property (
    (!i_sw_mode) [*4] |-> !o_block_start_pin_oe)
    else $error("block start driven in hardware mode");
  chk_hw_source: assert property (s_hw_run |->
    o_line_pos == i_encoder_bit && o_line_neg != i_encoder_bit)
    else $error("hardware mode not fed by encoder");
endmodule : atcp_chk

bind atcp_ctrl_port atcp_chk atcp_chk_i (.*);

// *** dv/tb_atcp_ctrl_port.sv ***
// Self-checking bench of the control port
module tb_atcp_ctrl_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_sw_mode = 1'b1;
  logic i_encoder_bit = 1'b0;
  logic i_external_encoded_in = 1'b0;
  logic i_cs_n, i_ctrl_serial_clock, i_ctrl_serial_in, o_ctrl_serial_out;
  logic o_ctrl_serial_out_oe, o_line_pos, o_line_neg, o_block_start_pin_oe;
  logic o_core_reset, o_powered_down, sdo;
  logic [7:0] o_asp_ctrl, r1, r2, r3;
  atcp_pkg::atcp_route_t o_route;
  int err_count = 0;
  int num_checks = 0;

  // System clock
  always #5 i_sys_clk = ~i_sys_clk;
  // Undriven data out floats, so a missing bit never reads as a match
  assign sdo = o_ctrl_serial_out_oe ? o_ctrl_serial_out : 1'bz;

  atcp_ctrl_port atcp_ctrl_port_i (.*);
  atcp_host atcp_host_i (.i_sys_clk(i_sys_clk), .o_cs_n(i_cs_n),
    .o_sclk(i_ctrl_serial_clock), .o_sdi(i_ctrl_serial_in), .i_sdo(sdo));

  // Compare and count
  task automatic chk(input string nm, input logic [7:0] got,
                     input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  // Expected line pair from the register images
  function automatic logic [1:0] line_exp;
    logic s;
    s = (i_sw_mode && r1[3]) ? i_external_encoded_in : i_encoder_bit;
    if (r2[0] || r2[3] || (i_sw_mode && r1[7])) return 2'b00;
    return {s, ~s};
  endfunction : line_exp

  function automatic atcp_pkg::atcp_route_t route_exp;
    return {r1[2], r1[4], r1[4] & r1[5], r1[6], r1[6] & r1[5], r1[1],
            r2[2:1]};
  endfunction : route_exp

  // Read three bytes from header h and compare
  task automatic rd3(input logic [7:0] h, input logic [7:0] a, b, c);
    atcp_host_i.rx_q.delete();
    atcp_host_i.xfer(h, 8'($urandom), 3);
    chk("rd0", atcp_host_i.rx_q[0], a);
    chk("rd1", atcp_host_i.rx_q[1], b);
    chk("rd2", atcp_host_i.rx_q[2], c);
  endtask : rd3

  // Random line sources, then output comparisons
  task automatic outs;
    repeat (4) begin
      @(negedge i_sys_clk);
      i_encoder_bit = 1'($urandom);
      i_external_encoded_in = 1'($urandom);
      repeat (4) @(negedge i_sys_clk);
      chk("line", {6'h0, o_line_pos, o_line_neg}, {6'h0, line_exp()});
      chk("route", o_route, route_exp());
    end
    chk("asp", o_asp_ctrl, r3);
    chk("bls", {7'h0, o_block_start_pin_oe}, {7'h0, i_sw_mode & r1[0]});
  endtask : outs

  // Main sequence
  initial begin
    r1 = 8'($urandom(66));
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    rd3(8'h80, 8'h00, 8'h00, 8'h03);
    rd3(8'h83, 8'h00, 8'h00, 8'h00);
    for (int i = 0; i < 6; i++) begin
      r1 = (i == 0) ? 8'h08 : (i == 1) ? 8'h80 : 8'($urandom);
      r2 = 8'($urandom) & 8'h06;
      r3 = 8'($urandom);
      atcp_host_i.tx_q = '{8'($urandom), r1, r2, r3};
      atcp_host_i.xfer(8'h00, 8'($urandom), 4);
      rd3(8'hC1, r1, r3, 8'h00);
      rd3(8'h80, 8'h00, r1, r2);
      outs();
    end
    atcp_host_i.tx_q = '{8'h0A};
    atcp_host_i.xfer(8'h02, 8'($urandom), 1);
    chk("swrst", {7'h0, o_core_reset}, 8'h01);
    rd3(8'h81, 8'h00, 8'h0A, 8'h00);
    // Leave soft reset, then check hardware mode ignores bypass
    r1 = 8'h89;
    r2 = 8'h02;
    r3 = 8'h00;
    // Soft reset pins reg01 at reset, so clear it before writing reg01
    atcp_host_i.tx_q = '{r2};
    atcp_host_i.xfer(8'h02, 8'($urandom), 1);
    atcp_host_i.tx_q = '{r1};
    atcp_host_i.xfer(8'h01, 8'($urandom), 1);
    @(negedge i_sys_clk);
    i_sw_mode = 1'b0;
    outs();
    end_sim();
  end

  // Watchdog well past the expected run length
  initial begin
    #200000;
    err_count++;
    end_sim();
  end
endmodule : tb_atcp_ctrl_port
